//--- pkg/itstx_pkg.sv
// Constants, register map and states of the serial transmit transfer block.
// Assumes a 125 MHz system clock and a byte-wide serial transmitter.
package itstx_pkg;
  // ************************************************************
  // Clock and serial timing
  // ************************************************************
  localparam int CLK_HZ      = 125_000_000;
  localparam int BAUD_HZ_DEF = 115_200;
  localparam int DATA_BITS   = 8;
  localparam int FRAME_BITS  = DATA_BITS + 2;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STOP  = 8'h04;
  localparam logic [7:0] A_VBASE = 8'h08;
  localparam logic [7:0] A_VNUM  = 8'h0c;
  localparam logic [7:0] A_DSRC  = 8'h10;
  localparam logic [7:0] A_DCNT  = 8'h14;
  localparam logic [7:0] A_PRIO  = 8'h18;
  localparam logic [7:0] A_STAT  = 8'h1c;
  localparam logic [7:0] A_REN   = 8'h20;
  localparam logic [7:0] A_TBUF  = 8'h24;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int C_TXEN = 0;
  localparam int C_TIE  = 1;
  localparam int C_TEIE = 2;
  localparam int C_MODE = 3;
  localparam int C_GIM  = 4;
  localparam int C_DIE  = 5;
  localparam int C_BUSY = 8;
  localparam int S_TX   = 0;
  localparam int S_DTC  = 1;
  localparam int S_DMA  = 2;
  localparam int I_EMPTY = 0;
  localparam int I_END   = 1;
  localparam int I_DMA   = 2;
  localparam int NIRQ    = 3;
  localparam int PRIO_W  = 4;
  localparam int VB_LOW  = 12;
  localparam logic [5:0]  CTRL_RST = 6'h00;
  localparam logic [2:0]  STOP_RST = 3'h7;
  localparam logic [31:0] INFO_CNT_OFS = 32'h0000_0004;

  typedef enum logic [2:0] {
    ST_IDLE, ST_VEC, ST_INF0, ST_INF1, ST_DATA, ST_LOAD, ST_WB
  } itstx_state_e;
endpackage

//--- rtl/itstx_shifter.sv
// Serial frame shifter: start bit, data LSB first, one stop bit.
// Assumes a one-cycle baud tick from the parent and a load only while idle.
`timescale 1ns/1ps
`default_nettype none
module itstx_shifter
  import itstx_pkg::*;
#(
  parameter int DW = DATA_BITS
)
(
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic          en,
  input  wire logic          tick,
  input  wire logic          load,
  input  wire logic [DW-1:0] data,
  output logic               busy,
  output logic               done,
  output logic               txd
);
  localparam int FW = DW + 2;

  logic [FW-1:0] sh_reg;
  logic [3:0]    bits_reg;
  logic          busy_reg;
  logic          done_reg;
  logic          txd_reg;

  // ************************************************************
  // Shift engine
  // ************************************************************
  // Disable drops the frame at once; the line is idle high afterwards
  always_ff @(posedge clock)
  begin
    if (srst || !en)
    begin
      sh_reg   <= '1;
      bits_reg <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      txd_reg  <= 1'b1;
    end
    else
    begin
      done_reg <= 1'b0;
      if (load && !busy_reg)
      begin
        sh_reg   <= {1'b1, data, 1'b0};
        bits_reg <= 4'(FW);
        busy_reg <= 1'b1;
      end
      else if (busy_reg && tick)
      begin
        if (bits_reg != 4'h0)
        begin
          txd_reg  <= sh_reg[0];
          sh_reg   <= {1'b1, sh_reg[FW-1:1]};
          bits_reg <= bits_reg - 4'h1;
        end
        else
        begin
          // Stop bit has now held a full period
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign txd  = txd_reg;
endmodule
`default_nettype wire

//--- rtl/itstx_top.sv
// Interrupt-driven transfer of memory bytes into a serial transmitter,
// by descriptor fetch through a vector table or by a DMA channel.
// Assumes memory answers a read in the cycle after mem_rd, never stalls.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - enabling transmit raises an empty request
// - first empty request starts first byte fetch
// - each buffer-to-shifter move requests next byte
// - last byte loaded raises a completion interrupt
// - end request once last frame fully out
// - disabled transmitter floats the serial pin
// - descriptor pointer read from base plus 4n
// - descriptor info lives in writable memory
// - interrupt needs mask flag, enable, priority, source
// - priority is a four-bit level per source
// - request sets its sticky pending flag
// - each module has its own stop bit
// - modules start stopped after reset
// - stopped module ignores writes, reads zero
module itstx_top
  import itstx_pkg::*;
#(
  parameter int BAUD_HZ = BAUD_HZ_DEF
)
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  output logic             txd_o,
  output logic             txd_oe,
  output logic             irq
);
  localparam int DIV = CLK_HZ / BAUD_HZ;

  logic [5:0]        ctrl_reg;
  logic [2:0]        stop_reg;
  logic [31:VB_LOW]  vbase_reg;
  logic [7:0]        vnum_reg;
  logic [31:0]       dsrc_reg;
  logic [15:0]       dcnt_reg;
  logic [11:0]       prio_reg;
  logic [NIRQ-1:0]   stat_reg;
  logic [NIRQ-1:0]   ren_reg;
  logic [31:0]       rdata_reg;
  logic [15:0]       baud_reg;
  logic [7:0]        tbuf_reg;
  logic              tbuf_full_reg;
  logic              tx_run_d_reg;
  logic              pend_reg;
  logic              ddone_reg;
  logic              mode_reg;
  itstx_state_e      st_reg;
  itstx_state_e      st_next;
  logic [31:0]       info_reg;
  logic [31:0]       src_reg;
  logic [15:0]       cnt_reg;
  logic              tx_on;
  logic              dtc_on;
  logic              dma_on;
  logic              tx_run;
  logic              tick;
  logic              move;
  logic              empty_req;
  logic              end_req;
  logic              route_d;
  logic              route_m;
  logic              dcomp;
  logic              dma_done;
  logic              empty_cpu;
  logic              fsm_load;
  logic              cpu_load;
  logic              sh_busy;
  logic              sh_done;
  logic              sh_txd;
  logic [NIRQ-1:0]   accept;
  logic [NIRQ-1:0]   set_vec;
  logic              wr_ctrl;

  // ************************************************************
  // Module stop and register port
  // ************************************************************
  assign tx_on  = !stop_reg[S_TX];
  assign dtc_on = !stop_reg[S_DTC];
  assign dma_on = !stop_reg[S_DMA];
  assign wr_ctrl = reg_wr && reg_addr == A_CTRL && tx_on;

  always_ff @(posedge clock)
  begin
    if (srst)
      stop_reg <= STOP_RST;
    else if (reg_wr && reg_addr == A_STOP)
      stop_reg <= reg_wdata[2:0];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      ctrl_reg <= CTRL_RST;
    else if (wr_ctrl)
      ctrl_reg <= reg_wdata[5:0];
  end

  // Base is held without its low bits, so the table stays aligned
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      vbase_reg <= '0;
      vnum_reg  <= 8'h00;
    end
    else if (reg_wr && dtc_on)
    begin
      if (reg_addr == A_VBASE)
        vbase_reg <= reg_wdata[31:VB_LOW];
      else if (reg_addr == A_VNUM)
        vnum_reg <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      prio_reg <= 12'h000;
      ren_reg  <= '0;
    end
    else if (reg_wr && reg_addr == A_PRIO)
      prio_reg <= reg_wdata[11:0];
    else if (reg_wr && reg_addr == A_REN)
      ren_reg <= reg_wdata[NIRQ-1:0];
  end

  // Reads of a stopped module return zero
  always_ff @(posedge clock)
  begin
    if (srst)
      rdata_reg <= 32'h0000_0000;
    else if (!reg_rd)
      rdata_reg <= 32'h0000_0000;
    else if (reg_addr == A_CTRL && tx_on)
      rdata_reg <= {23'h0, sh_busy | tbuf_full_reg, 2'b00, ctrl_reg};
    else if (reg_addr == A_STOP)
      rdata_reg <= {29'h0, stop_reg};
    else if (reg_addr == A_VBASE && dtc_on)
      rdata_reg <= {vbase_reg, 12'h000};
    else if (reg_addr == A_VNUM && dtc_on)
      rdata_reg <= {24'h0, vnum_reg};
    else if (reg_addr == A_DSRC && dma_on)
      rdata_reg <= dsrc_reg;
    else if (reg_addr == A_DCNT && dma_on)
      rdata_reg <= {16'h0, dcnt_reg};
    else if (reg_addr == A_PRIO)
      rdata_reg <= {20'h0, prio_reg};
    else if (reg_addr == A_STAT)
      rdata_reg <= {29'h0, stat_reg};
    else if (reg_addr == A_REN)
      rdata_reg <= {29'h0, ren_reg};
    else
      rdata_reg <= 32'h0000_0000;
  end
  assign reg_rdata = rdata_reg;

  // ************************************************************
  // Interrupt gating
  // ************************************************************
  assign set_vec = {dma_done, end_req, empty_cpu};

  // A new event in the clearing read's cycle stays pending
  always_ff @(posedge clock)
  begin
    if (srst)
      stat_reg <= '0;
    else if (reg_rd && reg_addr == A_STAT)
      stat_reg <= set_vec;
    else
      stat_reg <= stat_reg | set_vec;
  end

  genvar gi;
  for (gi = 0; gi < NIRQ; gi++)
  begin : g_acc
    assign accept[gi] = ctrl_reg[C_GIM] && ren_reg[gi]
                        && prio_reg[gi*PRIO_W +: PRIO_W] != 4'h0;
  end
  // Level zero masks a source, as the lowest priority
  assign irq = |(stat_reg & accept
                 & {ctrl_reg[C_DIE], ctrl_reg[C_TEIE], ctrl_reg[C_TIE]});

  // ************************************************************
  // Transmitter
  // ************************************************************
  assign tx_run = ctrl_reg[C_TXEN] && tx_on;

  always_ff @(posedge clock)
  begin
    if (srst || !tx_run)
      baud_reg <= 16'h0000;
    else if (tick)
      baud_reg <= 16'h0000;
    else
      baud_reg <= baud_reg + 16'h0001;
  end
  assign tick = baud_reg == 16'(DIV - 1);

  always_ff @(posedge clock)
  begin
    if (srst)
      tx_run_d_reg <= 1'b0;
    else
      tx_run_d_reg <= tx_run;
  end

  assign move      = tx_run && tbuf_full_reg && !sh_busy;
  assign empty_req = (tx_run && !tx_run_d_reg)
                     || move;
  assign end_req   = sh_done && !tbuf_full_reg;
  assign cpu_load  = reg_wr && reg_addr == A_TBUF && tx_on;

  always_ff @(posedge clock)
  begin
    if (srst)
      tbuf_reg <= 8'h00;
    else if (fsm_load)
      tbuf_reg <= mem_rdata[7:0];
    else if (cpu_load)
      tbuf_reg <= reg_wdata[7:0];
  end

  // Load beats move: the shifter takes the old byte in that cycle
  always_ff @(posedge clock)
  begin
    if (srst || !tx_run)
      tbuf_full_reg <= 1'b0;
    else if (fsm_load || cpu_load)
      tbuf_full_reg <= 1'b1;
    else if (move)
      tbuf_full_reg <= 1'b0;
  end

  itstx_shifter #(.DW(DATA_BITS)) u_shift (
    .clock (clock),
    .srst  (srst),
    .en    (tx_run),
    .tick  (tick),
    .load  (move),
    .data  (tbuf_reg),
    .busy  (sh_busy),
    .done  (sh_done),
    .txd   (sh_txd)
  );
  assign txd_o  = sh_txd;
  assign txd_oe = tx_run;

  // ************************************************************
  // Transfer sequencer
  // ************************************************************
  assign route_d = ctrl_reg[C_MODE] && dtc_on && !ddone_reg;
  assign route_m = !ctrl_reg[C_MODE] && dma_on && dcnt_reg != 16'h0000;
  assign fsm_load  = st_reg == ST_LOAD && tx_run;
  assign dcomp     = mode_reg && ((st_reg == ST_LOAD && cnt_reg == 16'h0001)
                     || (st_reg == ST_DATA && mem_rdata[15:0] == 16'h0000));
  assign dma_done  = !mode_reg && st_reg == ST_LOAD && dcnt_reg == 16'h0001;
  assign empty_cpu = (empty_req && !(route_d || route_m)) || dcomp;

  always_ff @(posedge clock)
  begin
    if (srst)
      pend_reg <= 1'b0;
    else if (empty_req && (route_d || route_m))
      pend_reg <= 1'b1;
    else if (st_reg == ST_IDLE)
      pend_reg <= 1'b0;
  end

  // Descriptor path stays closed after completion until re-armed
  always_ff @(posedge clock)
  begin
    if (srst)
      ddone_reg <= 1'b0;
    else if (dcomp)
      ddone_reg <= 1'b1;
    else if (reg_wr && reg_addr == A_VNUM && dtc_on)
      ddone_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      dsrc_reg <= 32'h0000_0000;
      dcnt_reg <= 16'h0000;
    end
    else if (st_reg == ST_LOAD && !mode_reg)
    begin
      dsrc_reg <= dsrc_reg + 32'h0000_0001;
      dcnt_reg <= dcnt_reg - 16'h0001;
    end
    else if (reg_wr && reg_addr == A_DSRC && dma_on)
      dsrc_reg <= reg_wdata;
    else if (reg_wr && reg_addr == A_DCNT && dma_on)
      dcnt_reg <= reg_wdata[15:0];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st_reg   <= ST_IDLE;
      mode_reg <= 1'b0;
      info_reg <= 32'h0000_0000;
      src_reg  <= 32'h0000_0000;
      cnt_reg  <= 16'h0000;
    end
    else
    begin
      st_reg <= st_next;
      if (st_reg == ST_IDLE)
        mode_reg <= route_d;
      if (st_reg == ST_INF0)
        info_reg <= mem_rdata;
      if (st_reg == ST_INF1)
        src_reg <= mem_rdata;
      if (st_reg == ST_DATA && mode_reg)
        cnt_reg <= mem_rdata[15:0];
    end
  end

  // Memory strobes are decoded from the state so a read answers in one step
  always_comb
  begin
    st_next   = st_reg;
    mem_rd    = 1'b0;
    mem_wr    = 1'b0;
    mem_addr  = 32'h0000_0000;
    mem_wdata = 32'h0000_0000;
    case (st_reg)
      ST_IDLE:
      begin
        if (pend_reg && route_d)
          st_next = ST_VEC;
        else if (pend_reg && route_m)
          st_next = ST_DATA;
      end
      ST_VEC:
      begin
        mem_rd   = 1'b1;
        mem_addr = {vbase_reg, 12'h000} + {22'h0, vnum_reg, 2'b00};
        st_next  = ST_INF0;
      end
      ST_INF0:
      begin
        mem_rd   = 1'b1;
        mem_addr = mem_rdata;
        st_next  = ST_INF1;
      end
      ST_INF1:
      begin
        mem_rd   = 1'b1;
        mem_addr = info_reg + INFO_CNT_OFS;
        st_next  = ST_DATA;
      end
      ST_DATA:
      begin
        if (mode_reg && mem_rdata[15:0] == 16'h0000)
          st_next = ST_IDLE;
        else
        begin
          mem_rd   = 1'b1;
          mem_addr = mode_reg ? src_reg : dsrc_reg;
          st_next  = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        if (mode_reg)
        begin
          mem_wr    = 1'b1;
          mem_addr  = info_reg;
          mem_wdata = src_reg + 32'h0000_0001;
          st_next   = ST_WB;
        end
        else
          st_next = ST_IDLE;
      end
      ST_WB:
      begin
        mem_wr    = 1'b1;
        mem_addr  = info_reg + INFO_CNT_OFS;
        mem_wdata = {16'h0, cnt_reg - 16'h0001};
        st_next   = ST_IDLE;
      end
      default:
        st_next = ST_IDLE;
    endcase
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_en_req;
    $rose(tx_run) |-> empty_req ##1 (pend_reg || stat_reg[I_EMPTY]);
  endproperty
  a_en_req: assert property (p_en_req) else $error("no request on enable");

  property p_first_load;
    (st_reg == ST_IDLE && pend_reg && route_m && tx_run) |-> ##1 st_reg == ST_DATA ##1 fsm_load;
  endproperty
  a_first_load: assert property (p_first_load) else $error("byte not loaded");

  property p_move_req;
    move |-> empty_req ##1 !tbuf_full_reg || $past(fsm_load) || $past(cpu_load);
  endproperty
  a_move_req: assert property (p_move_req) else $error("move without request");

  property p_dma_done;
    dma_done |=> stat_reg[I_DMA];
  endproperty
  a_dma_done: assert property (p_dma_done) else $error("dma end lost");

  property p_end;
    ($fell(sh_busy) && tx_run && !tbuf_full_reg) |-> txd_o ##1 stat_reg[I_END];
  endproperty
  a_end: assert property (p_end) else $error("end request lost");

  property p_float;
    !tx_run |-> !txd_oe;
  endproperty
  a_float: assert property (p_float) else $error("pin driven while off");

  property p_vec;
    st_reg == ST_VEC |-> mem_rd && mem_addr[11:0] == {2'b00, vnum_reg, 2'b00};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector address");

  property p_gate;
    irq |-> ctrl_reg[C_GIM] && (|ren_reg) && prio_reg != 12'h000;
  endproperty
  a_gate: assert property (p_gate) else $error("irq without enables");

  property p_flag;
    empty_cpu |=> stat_reg[I_EMPTY];
  endproperty
  a_flag: assert property (p_flag) else $error("empty flag lost");

  property p_stopped;
    (reg_wr && reg_addr == A_CTRL && !tx_on) |=> $stable(ctrl_reg);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped write taken");

  property p_wb;
    (st_reg == ST_LOAD && mode_reg) |-> mem_wr ##1 (st_reg == ST_WB && mem_wr) ##1 st_reg == ST_IDLE;
  endproperty
  a_wb: assert property (p_wb) else $error("no write back");

  c_dcomp: cover property (dcomp);
  c_dma: cover property (dma_done);
  c_end: cover property (end_req ##1 irq);
endmodule
`default_nettype wire

//--- test/itstx_mem_model.sv
// Behavioural system memory on the far side of the transfer block.
// Assumes one-cycle read latency, no stall; the bench preloads it.
`timescale 1ns/1ps
`default_nettype none
module itstx_mem_model
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata
);
  // ************************************************************
  // Storage
  // ************************************************************
  // One word per byte address keeps byte fetches trivial
  logic [31:0] mem [0:8191];

  // Writable store for vector table and transfer info
  always @(posedge clock)
  begin
    if (mem_wr)
    begin
      mem[mem_addr[12:0]] <= mem_wdata;
    end
  end

  // ************************************************************
  // Read answer
  // ************************************************************
  // Inverted every cycle outside an answer: toggles, so stale data is never trusted
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      mem_rdata <= 32'h0000_0000;
    end
    else if (mem_rd)
    begin
      mem_rdata <= mem[mem_addr[12:0]];
    end
    else
    begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the serial transmit transfer block.
// Assumes the memory model answers reads one cycle later.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import itstx_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  localparam int DIV = 10;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, rd_val;
  logic        mem_rd, mem_wr, txd_o, txd_oe, irq;
  logic [7:0]  rx_b;
  logic [7:0]  rx_q[$];
  logic [7:0]  exp_q[$] = '{8'h5a, 8'hc3, 8'h81, 8'h3c, 8'ha7};
  int          miscompares = 0;
  int          total_checks = 0;

  always #4 clock = ~clock;

  // Short baud divisor keeps each frame at 100 cycles
  itstx_top #(.BAUD_HZ(12_500_000)) u_dut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .txd_o(txd_o), .txd_oe(txd_oe), .irq(irq));
  itstx_mem_model u_mem (.clock(clock), .srst(srst), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ************************************************************
  // Compare, bus and closing tasks
  // ************************************************************
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A spare cycle after each strobe avoids a double assignment per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd_val = reg_rdata;
    chk32(rd_val & m, e);
    @(posedge clock);
  endtask

  task automatic pins(input logic e_irq, input logic e_oe);
    @(negedge clock);
    chk1(irq, e_irq);
    chk1(txd_oe, e_oe);
    @(posedge clock);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 1000)
    begin
      @(negedge clock);
      n++;
    end
    chk1(irq, 1'b1);
    @(posedge clock);
  endtask

  task automatic wrap_up;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ************************************************************
  // Serial line monitor: mid-bit sampling at the falling edge
  // ************************************************************
  initial
  begin
    forever
    begin
      @(negedge clock);
      if (txd_oe === 1'b1 && txd_o === 1'b0)
      begin
        repeat (4) @(negedge clock);
        chk1(txd_o, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
          repeat (DIV) @(negedge clock);
          rx_b[i] = txd_o;
        end
        repeat (DIV) @(negedge clock);
        chk1(txd_o, 1'b1);
        rx_q.push_back(rx_b);
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    wrap_up();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    u_mem.mem[13'h100c] = 32'h0000_0200;
    u_mem.mem[13'h0200] = 32'h0000_0300;
    u_mem.mem[13'h0204] = 32'h0000_0003;
    u_mem.mem[13'h0300] = 32'hffff_ff5a;
    u_mem.mem[13'h0301] = 32'h0000_00c3;
    u_mem.mem[13'h0302] = 32'h1234_5681;
    u_mem.mem[13'h0400] = 32'h0000_003c;
    u_mem.mem[13'h0401] = 32'h0000_00a7;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    pins(1'b0, 1'b0);
    rchk(A_STOP, '1, 32'h0000_0007);
    wr(A_CTRL, 32'h0000_0001);
    rchk(A_CTRL, '1, 32'h0000_0000);
    wr(A_STOP, 32'h0000_0006);
    wr(A_VBASE, 32'h0000_1fff);
    rchk(A_VBASE, '1, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0002);
    rchk(A_CTRL, 32'h0000_00ff, 32'h0000_0002);
    wr(A_STOP, 32'h0000_0000);
    rchk(8'h3c, '1, 32'h0000_0000);
    wr(A_VBASE, 32'h0000_1fff);
    rchk(A_VBASE, '1, 32'h0000_1000);
    wr(A_VNUM, 32'h0000_0003);
    wr(A_PRIO, 32'h0000_0111);
    rchk(A_PRIO, 32'h0000_0fff, 32'h0000_0111);
    wr(A_REN, 32'h0000_0007);
    // Descriptor path: three bytes, completion after the last load
    wr(A_CTRL, 32'h0000_001b);
    pins(1'b0, 1'b1);
    wait_irq();
    rchk(A_STAT, 32'h0000_0001, 32'h0000_0001);
    pins(1'b0, 1'b1);
    wr(A_CTRL, 32'h0000_001d);
    wait_irq();
    chk32(32'(rx_q.size()), 32'h0000_0003);
    wr(A_CTRL, 32'h0000_000d);
    pins(1'b0, 1'b1);
    wr(A_CTRL, 32'h0000_001d);
    pins(1'b1, 1'b1);
    wr(A_PRIO, 32'h0000_0101);
    pins(1'b0, 1'b1);
    wr(A_PRIO, 32'h0000_0111);
    rchk(A_STAT, 32'h0000_0002, 32'h0000_0002);
    pins(1'b0, 1'b1);
    wr(A_CTRL, 32'h0000_0000);
    pins(1'b0, 1'b0);
    chk32(u_mem.mem[13'h0200], 32'h0000_0303);
    chk32(u_mem.mem[13'h0204], 32'h0000_0000);
    // DMA path: two bytes, DMA interrupt flagged one cycle after the last load
    wr(A_DSRC, 32'h0000_0400);
    wr(A_DCNT, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_0031);
    wait_irq();
    rchk(A_STAT, 32'h0000_0004, 32'h0000_0004);
    rchk(A_DSRC, '1, 32'h0000_0402);
    rchk(A_DCNT, 32'h0000_ffff, 32'h0000_0000);
    // Two frames of ten bits each still to leave the line
    repeat (25 * DIV) @(posedge clock);
    chk32(32'(rx_q.size()), 32'h0000_0005);
    for (int i = 0; i < 5; i++)
    begin
      chk32({24'h0, rx_q[i]}, {24'h0, exp_q[i]});
    end
    // Unrouted empty request and end of the last frame both flagged
    rchk(A_STAT, 32'h0000_0007, 32'h0000_0003);
    // CPU byte with no transfer path armed
    wr(A_TBUF, 32'h0000_0096);
    rchk(A_CTRL, 32'h0000_0100, 32'h0000_0100);
    repeat (12 * DIV) @(posedge clock);
    chk32(32'(rx_q.size()), 32'h0000_0006);
    chk32({24'h0, rx_q[5]}, 32'h0000_0096);
    rchk(A_CTRL, 32'h0000_0100, 32'h0000_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
